//--- rtcc_pkg.sv
// rtcc_pkg: constants, register map and state record of the rtc core
// assumes a 50 MHz system clock and a 32.768 kHz oscillator tick input
package rtcc_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [16:0] ADDR_FLAGS = 17'h1fff0;
    localparam logic [16:0] ADDR_CAL   = 17'h1fff8;
    localparam logic [16:0] ADDR_IRQ   = 17'h1fff6;
    localparam logic [3:0]  LO_CENT    = 4'h1;
    localparam logic [3:0]  LO_ALM0    = 4'h2;
    localparam logic [3:0]  LO_ALM3    = 4'h5;
    localparam logic [3:0]  LO_SEC     = 4'h9;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FLG_R     = 0;
    localparam int FLG_W     = 1;
    localparam int FLG_CAL   = 2;
    localparam int FLG_OSCILLATOR_FAILED_FLAG  = 4;
    localparam int FLG_AF    = 6;
    localparam int CAL_SIGN  = 5;
    localparam int CAL_DIS   = 7;
    localparam int IRQ_AIE   = 3;
    localparam int T_SEC     = 0;
    localparam int T_MIN     = 1;
    localparam int T_HOUR    = 2;
    localparam int T_DAY     = 3;
    localparam int T_DATE    = 4;
    localparam int T_MONTH   = 5;
    localparam int T_YEAR    = 6;
    localparam int T_CENT    = 7;

    // ------------------------------------------------------------
    // masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0][7:0] TIME_MASK = {8'hff, 8'hff, 8'h1f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f};
    localparam logic [7:0][7:0] TIME_RST  = {8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [3:0][7:0] ALM_RST   = {8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0]      FLG_WMASK = 8'h07;
    localparam logic [7:0]      CAL_MASK  = 8'hbf;
    localparam logic [7:0]      IRQ_MASK  = 8'h08;
    localparam logic [7:0]      FLAGS_RST = 8'h00;
    localparam logic [7:0]      CAL_RST   = 8'h00;
    localparam logic [7:0]      IRQ_RST   = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [15:0] PRE_NOM       = 16'd32767;
    localparam logic [15:0] CAL_NEG_CYC   = 16'd128;
    localparam logic [15:0] CAL_POS_CYC   = 16'd256;
    localparam logic [5:0]  CAL_MIN_LAST  = 6'd61;
    localparam logic [4:0]  TEST_HALF     = 5'd31;
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          OSC_START_S   = 10;
    localparam int          OSC_START_CYC = OSC_START_S * CLK_HZ;
    localparam int          REFRESH_MS    = 20;
    localparam int          REFRESH_CYC   = REFRESH_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0][7:0] cnt;
        logic [7:0][7:0] vis;
        logic [7:0][7:0] base;
        logic [3:0][7:0] alm;
        logic [7:0]      flags;
        logic [7:0]      cal;
        logic [7:0]      irq;
        logic [15:0]     pre;
        logic [5:0]      cmin;
        logic [4:0]      tst;
        logic            sq;
        logic [28:0]     osc_wait;
        logic            osc_ok;
        logic            wr_prev;
        logic            rdf_prev;
        logic            tick_d;
        logic [7:0]      dq;
    } rtcc_state_t;

    localparam rtcc_state_t ST_RST = '{cnt: TIME_RST, vis: TIME_RST, base: TIME_RST, alm: ALM_RST,
                                       flags: FLAGS_RST, cal: CAL_RST, irq: IRQ_RST, default: '0};

endpackage : rtcc_pkg

//--- rtcc_core.sv
// rtcc_core: bcd clock, calendar, alarm and calibration behind sram-style pins
// assumes bus pins and the oscillator tick are synchronous to clk_sys
//
// Contract
// - time and alarm kept in bcd; user copy separate from running counters.
// - count seconds up to century rollover, with weekday, month length, leap years.
// - eight timekeeping registers written and read; unused bits read zero.
// - read-hold bit freezes user copy while counters keep running.
// - user copy refreshed at once, all together, after read-hold clears.
// - write-hold halts updates; host writes base time in bcd.
// - clearing write-hold loads base time into counters.
// - oscillator-disable bit stops oscillator when 1; reset value 0.
// - oscillator given up to ten seconds to start after enable.
// - enabled oscillator not started by then sets failed flag; host writes 0 to clear.
// - oscillator failure restores time to base; calibration untouched.
// - five-bit calibration magnitude plus sign bit, 1 positive.
// - 64-minute cycle; one second shortened 128 or lengthened 256 cycles.
// - magnitude n adjusts the first 2n minutes of the cycle.
// - calibration-test bit toggles interrupt pin at 512 Hz, uncalibrated.
// - four alarm fields; top bit 0 includes field in comparison.
// - match bits all 1 fire each second; more fields, rarer alarm.
// - alarm match sets alarm flag; may drive interrupt pin.
// - reading flags register clears the alarm flag.
// - alarm interrupt enable routes alarm flag to interrupt pin.
`timescale 1ns/1ps

module rtcc_core
#(
    parameter int OSC_START_CYC_P = rtcc_pkg::OSC_START_CYC
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // memory-style bus
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    // oscillator
    input  wire logic        osc_tick,
    output logic             osc_stop,
    // interrupt
    output logic             int_out
);
    import rtcc_pkg::*;

    localparam logic [28:0] OSC_WAIT_LAST = 29'(OSC_START_CYC_P - 1);

    rtcc_state_t s_r;
    rtcc_state_t s_nxt;
    logic        wr_act;
    logic        take;
    logic        rd_flags;
    logic        in_rtc;
    logic        is_time;
    logic [2:0]  tidx;
    logic [1:0]  aidx;
    logic        tick;
    logic        adj;
    logic [15:0] term;
    logic        fail;
    logic [3:0]  match;
    logic        alm_hit;

    // ------------------------------------------------------------
    // bcd calendar helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] b);
        return (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : {b[7:4], b[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic div4(input logic [7:0] b);
        return b[4] ? (b[3:0] == 4'h2 || b[3:0] == 4'h6)
                    : (b[3:0] == 4'h0 || b[3:0] == 4'h4 || b[3:0] == 4'h8);
    endfunction : div4

    function automatic logic [7:0] mdays(input logic [7:0] mo, input logic [7:0] yr, input logic [7:0] ce);
        logic leap;
        leap = div4(yr) && (yr != 8'h00 || div4(ce));
        case (mo)
            8'h02:                      mdays = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
            default:                    mdays = 8'h31;
        endcase
    endfunction : mdays

    function automatic logic [7:0][7:0] adv(input logic [7:0][7:0] t);
        logic [7:0][7:0] r;
        logic            c;
        r = t;
        c = (t[T_SEC] == 8'h59);
        r[T_SEC] = c ? 8'h00 : bcd_inc(t[T_SEC]);
        if (c)
        begin
            c = (t[T_MIN] == 8'h59);
            r[T_MIN] = c ? 8'h00 : bcd_inc(t[T_MIN]);
        end
        if (c)
        begin
            c = (t[T_HOUR] == 8'h23);
            r[T_HOUR] = c ? 8'h00 : bcd_inc(t[T_HOUR]);
            r[T_DAY]  = (c && t[T_DAY] == 8'h07) ? 8'h01 : (c ? bcd_inc(t[T_DAY]) : t[T_DAY]);
        end
        if (c)
        begin
            c = (t[T_DATE] == mdays(t[T_MONTH], t[T_YEAR], t[T_CENT]));
            r[T_DATE] = c ? 8'h01 : bcd_inc(t[T_DATE]);
        end
        if (c)
        begin
            c = (t[T_MONTH] == 8'h12);
            r[T_MONTH] = c ? 8'h01 : bcd_inc(t[T_MONTH]);
        end
        if (c)
        begin
            c = (t[T_YEAR] == 8'h99);
            r[T_YEAR] = c ? 8'h00 : bcd_inc(t[T_YEAR]);
        end
        if (c)
        begin
            r[T_CENT] = (t[T_CENT] == 8'h99) ? 8'h00 : bcd_inc(t[T_CENT]);
        end
        return r;
    endfunction : adv

    // ------------------------------------------------------------
    // alarm field compare
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_alm
            localparam int CI = (gi == 3) ? T_DATE : gi;
            assign match[gi] = s_r.alm[gi][7] || (s_r.alm[gi][6:0] == s_r.cnt[CI][6:0]);
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt    = s_r;
        wr_act   = !ce_n && !we_n;
        take     = wr_act && !s_r.wr_prev;
        in_rtc   = (addr[16:4] == ADDR_FLAGS[16:4]);
        rd_flags = !ce_n && we_n && (addr == ADDR_FLAGS);
        is_time  = in_rtc && (addr[3:0] == LO_CENT || addr[3:0] >= LO_SEC);
        tidx     = (addr[3:0] == LO_CENT) ? 3'(T_CENT) : 3'(addr[3:0] - LO_SEC);
        aidx     = 2'(addr[3:0] - LO_ALM0);
        adj      = (s_r.cnt[T_SEC] == 8'h00) && (s_r.cmin < {s_r.cal[4:0], 1'b0})
                   && (s_r.cmin <= CAL_MIN_LAST);
        term     = !adj ? PRE_NOM
                 : (s_r.cal[CAL_SIGN] ? PRE_NOM + CAL_POS_CYC : PRE_NOM - CAL_NEG_CYC);
        tick     = osc_tick && !s_r.cal[CAL_DIS] && (s_r.pre == term);
        fail     = !s_r.cal[CAL_DIS] && !s_r.osc_ok && (s_r.osc_wait == OSC_WAIT_LAST);
        alm_hit  = s_r.tick_d && (&match);

        s_nxt.wr_prev  = wr_act;
        s_nxt.rdf_prev = rd_flags;
        s_nxt.tick_d   = tick;

        // oscillator divider and test square wave
        if (osc_tick && !s_r.cal[CAL_DIS])
        begin
            s_nxt.osc_ok = 1'b1;
            s_nxt.pre    = tick ? 16'h0000 : s_r.pre + 16'h0001;
            s_nxt.tst    = s_r.tst + 5'h01;
            if (s_r.tst == TEST_HALF)
                s_nxt.sq = !s_r.sq;
        end
        if (!s_r.cal[CAL_DIS] && !s_r.osc_ok)
            s_nxt.osc_wait = fail ? 29'h0 : s_r.osc_wait + 29'h1;
        if (s_r.cal[CAL_DIS])
        begin
            s_nxt.osc_ok   = 1'b0;
            s_nxt.osc_wait = 29'h0;
        end

        // running counters, one second per tick
        if (tick)
        begin
            s_nxt.cnt = adv(s_r.cnt);
            if (s_r.cnt[T_SEC] == 8'h59)
                s_nxt.cmin = s_r.cmin + 6'h01;
        end

        // user copy follows counters unless a hold bit is set
        if (!s_r.flags[FLG_R] && !s_r.flags[FLG_W])
            s_nxt.vis = s_r.cnt;

        // host writes
        if (take && in_rtc)
        begin
            if (addr == ADDR_FLAGS)
            begin
                s_nxt.flags = (s_r.flags & ~FLG_WMASK) | (dq_in & FLG_WMASK);
                if (!dq_in[FLG_OSCILLATOR_FAILED_FLAG])
                    s_nxt.flags[FLG_OSCILLATOR_FAILED_FLAG] = 1'b0;
                if (s_r.flags[FLG_W] && !dq_in[FLG_W])
                begin
                    s_nxt.cnt = s_r.base;
                    s_nxt.pre = 16'h0000;
                end
            end
            else if (addr == ADDR_CAL)
            begin
                s_nxt.cal = dq_in & CAL_MASK;
            end
            else if (addr == ADDR_IRQ)
            begin
                s_nxt.irq = dq_in & IRQ_MASK;
            end
            else if (addr[3:0] >= LO_ALM0 && addr[3:0] <= LO_ALM3)
            begin
                s_nxt.alm[aidx] = dq_in;
            end
            else if (is_time)
            begin
                s_nxt.base[tidx] = dq_in & TIME_MASK[tidx];
                s_nxt.vis[tidx]  = dq_in & TIME_MASK[tidx];
            end
        end

        // oscillator failure wins over a clear in the same cycle
        if (fail)
        begin
            s_nxt.flags[FLG_OSCILLATOR_FAILED_FLAG] = 1'b1;
            s_nxt.cnt             = s_r.base;
            s_nxt.vis             = s_r.base;
        end

        // alarm flag: cleared at end of a flags read, set wins
        if (s_r.rdf_prev && !rd_flags)
            s_nxt.flags[FLG_AF] = 1'b0;
        if (alm_hit)
            s_nxt.flags[FLG_AF] = 1'b1;

        // read data register
        if (!in_rtc)
            s_nxt.dq = 8'h00;
        else if (addr == ADDR_FLAGS)
            s_nxt.dq = s_r.flags;
        else if (addr == ADDR_CAL)
            s_nxt.dq = s_r.cal;
        else if (addr == ADDR_IRQ)
            s_nxt.dq = s_r.irq;
        else if (addr[3:0] >= LO_ALM0 && addr[3:0] <= LO_ALM3)
            s_nxt.dq = s_r.alm[aidx];
        else if (is_time)
            s_nxt.dq = s_r.vis[tidx];
        else
            s_nxt.dq = 8'h00;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= ST_RST;
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dq_out   = s_r.dq;
    assign dq_oe    = !ce_n && !oe_n && we_n && in_rtc;
    assign osc_stop = s_r.cal[CAL_DIS];
    assign int_out  = s_r.flags[FLG_CAL] ? s_r.sq
                    : (s_r.irq[IRQ_AIE] && s_r.flags[FLG_AF]);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_oscillator_failed_flag_on_fail: assert property (fail |=> s_r.flags[FLG_OSCILLATOR_FAILED_FLAG] && s_r.cnt == $past(s_r.base))
        else $error("oscillator failure did not set flag or restore base");
    a_read_hold: assert property (s_r.flags[FLG_R] && !take && !fail |=> $stable(s_r.vis))
        else $error("user time changed during read hold");
    a_vis_follow: assert property (!s_r.flags[FLG_R] && !s_r.flags[FLG_W] && !fail && !(take && is_time)
                                   |=> s_r.vis == $past(s_r.cnt))
        else $error("user time not refreshed from counters");
    a_base_load: assert property (take && addr == ADDR_FLAGS && s_r.flags[FLG_W] && !dq_in[FLG_W] && !fail
                                  |=> s_r.cnt == $past(s_r.base))
        else $error("base time not loaded on write hold release");
    a_alarm_set: assert property (s_r.tick_d && (&match) |=> s_r.flags[FLG_AF])
        else $error("alarm match did not set flag");
    a_af_clear: assert property (s_r.rdf_prev && !rd_flags && !alm_hit |=> !s_r.flags[FLG_AF])
        else $error("flags read did not clear alarm flag");
    a_int_test: assert property (s_r.flags[FLG_CAL] |-> int_out == s_r.sq)
        else $error("test output not on interrupt pin");
    a_int_alarm: assert property (!s_r.flags[FLG_CAL] && s_r.flags[FLG_AF] |-> int_out == s_r.irq[IRQ_AIE])
        else $error("interrupt pin disagrees with alarm enable");
    a_adj_len: assert property (tick && adj |-> s_r.pre != PRE_NOM)
        else $error("adjusted second has nominal length");

    c_alarm_hit: cover property (alm_hit);
    c_osc_fail: cover property (fail);
    c_base_load: cover property (take && addr == ADDR_FLAGS && s_r.flags[FLG_W] && !dq_in[FLG_W]);
    c_test_toggle: cover property (s_r.flags[FLG_CAL] ##1 $changed(int_out));

endmodule : rtcc_core

//--- rtcc_host_model.sv
// rtcc_host_model: host on the sram-style pins plus a crystal that ticks once per clk_sys cycle
// assumes one bench process calls its tasks; pins change on the falling edge
`timescale 1ns/1ps

module rtcc_host_model
(
    // clock
    input  wire logic        clk_sys,
    // crystal
    input  wire logic        osc_run,
    input  wire logic        osc_stop,
    output logic             osc_tick,
    // memory-style bus
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n,
    output logic      [16:0] addr,
    output logic      [7:0]  dq_in,
    input  wire logic [7:0]  dq_out,
    input  wire logic        dq_oe
);
    initial
    begin
        osc_tick = 1'b0;
        ce_n     = 1'b1;
        we_n     = 1'b1;
        oe_n     = 1'b1;
        addr     = 17'h00000;
        dq_in    = 8'h00;
    end

    // crystal stands still while disabled or dead
    always @(negedge clk_sys)
        osc_tick <= osc_run & ~osc_stop;

    // one write, we_n high again for a cycle after it
    task automatic bus_wr(input logic [16:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        ce_n  = 1'b0;
        we_n  = 1'b0;
        addr  = a;
        dq_in = d;
        @(negedge clk_sys);
        ce_n  = 1'b1;
        we_n  = 1'b1;
        dq_in = ~d;
    endtask : bus_wr

    // one read, data taken one edge after the address
    task automatic bus_rd(input logic [16:0] a, output logic [7:0] d, output logic oe);
        @(negedge clk_sys);
        ce_n = 1'b0;
        oe_n = 1'b0;
        addr = a;
        @(negedge clk_sys);
        d    = dq_out;
        oe   = dq_oe;
        ce_n = 1'b1;
        oe_n = 1'b1;
    endtask : bus_rd
endmodule : rtcc_host_model

//--- rtcc_core_tb_top.sv
// rtcc_core_tb_top: self-checking bench of the rtc core
// assumes rtcc_pkg and rtcc_host_model compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s expected %h seen %h", nm, e, g); end end

module rtcc_core_tb_top;
    import rtcc_pkg::*;
    localparam int OSC_WAIT = 200;
    localparam int SEC_CYC  = 32768;
    localparam logic [7:0][7:0] SET_V  = {8'h19, 8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
    localparam logic [7:0][7:0] ROLL_V = {8'h20, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    logic        clk_sys;
    logic        rst_n;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [16:0] addr;
    logic [7:0]  dq_in;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic        osc_tick;
    logic        osc_stop;
    logic        int_out;
    logic        osc_run;
    int          n_fail;
    int          n_checks;

    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    rtcc_core #(.OSC_START_CYC_P(OSC_WAIT)) rtcc_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .osc_tick(osc_tick), .osc_stop(osc_stop), .int_out(int_out));

    rtcc_host_model rtcc_host_model_i (.clk_sys(clk_sys), .osc_run(osc_run), .osc_stop(osc_stop),
        .osc_tick(osc_tick), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        rtcc_host_model_i.bus_wr(a, d);
    endtask : wr

    task automatic rd_chk(input logic [16:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        logic       o;
        rtcc_host_model_i.bus_rd(a, d, o);
        `CHK("dq_oe", 1'b1, o)
        `CHK(nm, e, d)
    endtask : rd_chk

    task automatic half_period(output logic [7:0] n);
        logic s;
        n = 8'h00;
        s = int_out;
        while (int_out === s && n < 8'h64)
        begin
            @(negedge clk_sys);
            n++;
        end
        n = 8'h00;
        s = int_out;
        while (int_out === s && n < 8'h64)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask : half_period

    task automatic test_done;
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        `CHK("osc_stop", 1'b0, osc_stop)
        `CHK("int_out", 1'b0, int_out)
        rd_chk(ADDR_FLAGS, 8'h00, "flags");
        rd_chk(ADDR_CAL, 8'h00, "cal");
        rd_chk(17'h1fffc, 8'h01, "day");
        rd_chk(17'h1fff9, 8'h00, "sec");
    endtask : t_reset_values

    task automatic t_cal_osc;
        wr(ADDR_CAL, 8'hff);
        rd_chk(ADDR_CAL, 8'hbf, "cal mask");
        `CHK("osc_stop", 1'b1, osc_stop)
        wr(17'h1fff7, 8'h5a);
        rd_chk(17'h1fff7, 8'h00, "unmapped");
        wr(ADDR_FLAGS, 8'h02);
        wr(17'h1fff9, 8'h42);
        wr(ADDR_FLAGS, 8'h00);
        wr(17'h1fff9, 8'h13);
        rd_chk(17'h1fff9, 8'h42, "sec follows counter");
        osc_run = 1'b0;
        wr(ADDR_CAL, 8'h1f);
        repeat (OSC_WAIT / 2) @(negedge clk_sys);
        rd_chk(ADDR_FLAGS, 8'h00, "flags in start wait");
        repeat (OSC_WAIT) @(negedge clk_sys);
        rd_chk(ADDR_FLAGS, 8'h10, "flags osc failed");
        rd_chk(17'h1fff9, 8'h13, "sec restored");
        rd_chk(ADDR_CAL, 8'h1f, "cal kept");
        osc_run = 1'b1;
        wr(ADDR_CAL, 8'h00);
        wr(ADDR_FLAGS, 8'h10);
        rd_chk(ADDR_FLAGS, 8'h10, "oscillator_failed_flag write one kept");
        wr(ADDR_FLAGS, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h00, "flags cleared");
    endtask : t_cal_osc

    task automatic t_set_time;
        wr(ADDR_FLAGS, 8'h02);
        wr(17'h1fffc, 8'hff);
        rd_chk(17'h1fffc, 8'h07, "day mask");
        for (int i = 0; i < 7; i++)
            wr(17'h1fff9 + 17'(i), SET_V[i]);
        wr(17'h1fff1, SET_V[7]);
        wr(ADDR_FLAGS, 8'h00);
        rd_chk(17'h1fffb, 8'h23, "hour loaded");
        repeat (SEC_CYC) @(negedge clk_sys);
        for (int i = 0; i < 7; i++)
            rd_chk(17'h1fff9 + 17'(i), ROLL_V[i], "rollover");
        rd_chk(17'h1fff1, ROLL_V[7], "century");
    endtask : t_set_time

    task automatic t_alarm_hold;
        logic [7:0] d;
        logic       o;
        for (int i = 0; i < 4; i++)
            wr(17'h1fff2 + 17'(i), 8'h80);
        wr(ADDR_IRQ, 8'h08);
        rtcc_host_model_i.bus_rd(ADDR_FLAGS, d, o);
        // negative step of one: the second at sec 00 of minute 1 ends 128 ticks early
        wr(ADDR_CAL, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        rd_chk(17'h1fff9, 8'h00, "sec before hold");
        repeat (SEC_CYC - 64) @(negedge clk_sys);
        rd_chk(17'h1fff9, 8'h00, "sec held");
        `CHK("int_out alarm", 1'b1, int_out)
        rd_chk(ADDR_FLAGS, 8'h41, "flags alarm");
        rd_chk(ADDR_FLAGS, 8'h01, "flags after read");
        @(negedge clk_sys);
        `CHK("int_out cleared", 1'b0, int_out)
        wr(ADDR_FLAGS, 8'h00);
        rd_chk(17'h1fff9, 8'h01, "sec refreshed");
        wr(ADDR_IRQ, 8'h00);
    endtask : t_alarm_hold

    task automatic t_cal_test;
        logic [7:0] n;
        wr(ADDR_FLAGS, 8'h04);
        half_period(n);
        `CHK("test half period", 8'h20, n)
        wr(ADDR_CAL, 8'h3f);
        half_period(n);
        `CHK("test half period cal", 8'h20, n)
        wr(ADDR_CAL, 8'h00);
        wr(ADDR_FLAGS, 8'h00);
    endtask : t_cal_test

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        rst_n    = 1'b0;
        osc_run  = 1'b1;
        n_fail   = 0;
        n_checks = 0;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset_values();
        t_cal_osc();
        t_set_time();
        t_alarm_hold();
        t_cal_test();
        test_done();
    end

    initial
    begin
        repeat (90000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end
endmodule : rtcc_core_tb_top
